// [test/ext_side_model.sv]
// far-side model: count pin driver, watchdog tick and clear source
// assumes it shares aclk with the timer block
`timescale 1ns/100ps
`default_nettype none
module ext_side_model (
   input  wire logic aclk,
   input  wire logic watchdog_timeout,
   output logic      external_count_input,
   output logic      watchdog_tick,
   output logic      watchdog_clear_instruction
);
   // idle levels from time zero
   initial begin
      external_count_input = 1'b0;
      watchdog_tick = 1'b0;
      watchdog_clear_instruction = 1'b0;
   end
   // level held 12 clocks so the phase sampler sees it
   task automatic pin(input logic v);
      @(posedge aclk) external_count_input <= v;
      repeat (12) @(posedge aclk);
   endtask
   // one-clock clear pulse
   task automatic wd_clear();
      @(posedge aclk) watchdog_clear_instruction <= 1'b1;
      @(posedge aclk) watchdog_clear_instruction <= 1'b0;
   endtask
   // ticks until the postscaler fires or lim runs out
   task automatic ticks(input int lim, output int n);
      bit hit;
      hit = 0;
      n = 0;
      while (!hit && n < lim) begin
         @(posedge aclk) watchdog_tick <= 1'b1;
         @(posedge aclk) watchdog_tick <= 1'b0;
         n++;
         repeat (3) @(negedge aclk) hit |= watchdog_timeout === 1'b1;
      end
   endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the timer/counter over AXI4-Lite
// assumes ext_side_model stands on the pin and watchdog side
`timescale 1ns/100ps
`default_nettype none
`include "timer0_params.svh"
module tb;
   import timer0_pkg::*;
   logic       aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic       awready, wready, bvalid, arready, rvalid, sleep;
   logic       external_count_input, watchdog_tick, timer_irq;
   logic       watchdog_clear_instruction, watchdog_timeout;
   logic [3:0] awaddr, araddr, wstrb;
   word_t      wdata, rdata, a, b;
   resp_t      bresp, rresp, rs;
   int         fail_count, check_count, cyc, n1, n2;
   timer0_core dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .external_count_input,
      .sleep, .watchdog_clear_instruction, .watchdog_tick,
      .watchdog_timeout, .timer_irq
   );
   ext_side_model m (
      .aclk, .watchdog_timeout, .external_count_input, .watchdog_tick,
      .watchdog_clear_instruction
   );
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // counted on the falling edge so tasks read it race-free
   always @(negedge aclk) cyc <= cyc + 1;
   task automatic chk(input string nm, input word_t e, input word_t g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ready sampled at the falling edge is what the next rising edge sees
   task automatic wr(input logic [3:0] ad, input byte_t d, output resp_t r);
      bit ha, hw, hb;
      int n;
      hb = 0;
      n = 0;
      @(posedge aclk);
      awaddr <= ad;
      wdata <= {24'h000000, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!hb && n < 100) begin
         @(negedge aclk);
         hb = !awvalid && !wvalid && bvalid === 1'b1;
         ha = awready === 1'b1;
         hw = wready === 1'b1;
         r = bresp;
         n++;
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
      end
      if (!hb) fail_count++;
   endtask
   // read issued one edge after cycle t, so spacing is exact
   task automatic rd(input logic [3:0] ad, input int t, output word_t d);
      bit ha, hr;
      int n;
      hr = 0;
      n = 0;
      while (cyc < t) @(posedge aclk);
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!hr && n < 100) begin
         @(negedge aclk);
         hr = !arvalid && rvalid === 1'b1;
         ha = arready === 1'b1;
         d = rdata;
         n++;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
      end
      if (!hr) fail_count++;
   endtask
   // count gained over gap clocks; starts clear of any write inhibit
   task automatic span(input int gap, input word_t e, input string nm);
      int t;
      t = cyc + 16;
      rd(`ADDR_COUNT, t, a);
      rd(`ADDR_COUNT, t + gap, b);
      chk(nm, e, byte_t'(b - a));
   endtask
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, sleep} = '0;
      {awaddr, araddr, wstrb, wdata, fail_count, check_count} = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`ADDR_COUNT, 0, a);
      chk("count reset", 32'h0, a);
      rd(`ADDR_OPTION, 0, a);
      chk("option reset", 32'hFF, a);
      rd(`ADDR_CONTROL, 0, a);
      chk("control reset", 32'h0, a);
      wr(`ADDR_STATUS, 8'h00, rs);
      chk("status write", 32'h2, rs);
      $display("test reset done");
      wr(`ADDR_OPTION, 8'h08, rs);
      wr(`ADDR_COUNT, 8'h00, rs);
      rd(`ADDR_STATUS, 0, a);
      chk("inhibit busy", 32'h1, |a[1:0]);
      span(40, 32'hA, "timer step");
      rd(`ADDR_STATUS, 0, a);
      chk("inhibit over", 32'h0, a);
      @(posedge aclk) sleep <= 1'b1;
      span(40, 32'h0, "sleep hold");
      @(posedge aclk) sleep <= 1'b0;
      $display("test timer done");
      for (int r = 0; r < 8; r++) begin
         wr(`ADDR_OPTION, byte_t'(r), rs);
         wr(`ADDR_COUNT, 8'h00, rs);
         span(12 << (r + 1), 32'h3, "prescale");
      end
      $display("test ratio done");
      wr(`ADDR_OPTION, 8'h08, rs);
      wr(`ADDR_COUNT, 8'hFE, rs);
      repeat (40) @(posedge aclk);
      rd(`ADDR_CONTROL, 0, a);
      chk("flag set", 32'h4, a);
      @(negedge aclk) chk("irq masked", 32'h0, timer_irq);
      wr(`ADDR_CONTROL, 8'h24, rs);
      @(negedge aclk) chk("irq on", 32'h1, timer_irq);
      wr(`ADDR_CONTROL, 8'h20, rs);
      repeat (40) @(posedge aclk);
      rd(`ADDR_CONTROL, 0, a);
      chk("flag cleared", 32'h20, a);
      @(negedge aclk) chk("irq off", 32'h0, timer_irq);
      $display("test overflow done");
      for (int e = 0; e < 2; e++) begin
         wr(`ADDR_OPTION, 8'h28 | byte_t'(e << 4), rs);
         rd(`ADDR_COUNT, 0, a);
         m.pin(1'b1);
         rd(`ADDR_COUNT, 0, b);
         chk("rise", word_t'(e == 0), byte_t'(b - a));
         m.pin(1'b0);
         rd(`ADDR_COUNT, 0, a);
         chk("fall", word_t'(e == 1), byte_t'(a - b));
      end
      wr(`ADDR_OPTION, 8'h20, rs);
      wr(`ADDR_COUNT, 8'h00, rs);
      m.pin(1'b0);
      repeat (8) begin
         m.pin(1'b1);
         m.pin(1'b0);
      end
      rd(`ADDR_COUNT, 0, a);
      chk("ext prescaled", 32'h4, a);
      $display("test counter done");
      wr(`ADDR_COUNT, 8'h00, rs);
      m.wd_clear();
      wr(`ADDR_OPTION, 8'h0B, rs);
      m.wd_clear();
      m.ticks(600, n1);
      m.ticks(1, n2);
      m.wd_clear();
      m.ticks(600, n2);
      chk("wd fired", 32'h1, word_t'(n1 < 600));
      chk("wd period", word_t'(n1), word_t'(n2));
      $display("test watchdog done");
      stop_test();
   end
   // hang guard: about seven times the expected run
   initial begin
      #2000000;
      fail_count++;
      stop_test();
   end
endmodule
`default_nettype wire

// [verilog/timer0_core.sv]
// timer/counter, shared 8-bit prescaler and AXI4-Lite register slave
// assumes the watchdog and sleep come from the core on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "timer0_params.svh"
module timer0_core (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [3:0]       awaddr,
   input  wire logic             awvalid,
   output logic                  awready,
   input  wire timer0_pkg::word_t wdata,
   input  wire logic [3:0]       wstrb,
   input  wire logic             wvalid,
   output logic                  wready,
   output timer0_pkg::resp_t     bresp,
   output logic                  bvalid,
   input  wire logic             bready,
   input  wire logic [3:0]       araddr,
   input  wire logic             arvalid,
   output logic                  arready,
   output timer0_pkg::word_t     rdata,
   output timer0_pkg::resp_t     rresp,
   output logic                  rvalid,
   input  wire logic             rready,
   input  wire logic             external_count_input,
   input  wire logic             sleep,
   input  wire logic             watchdog_clear_instruction,
   input  wire logic             watchdog_tick,
   output logic                  watchdog_timeout,
   output logic                  timer_irq
);
   import timer0_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // state
   byte_t      count_q, count_d;
   byte_t      opt_q, opt_d;
   byte_t      ctl_q, ctl_d;
   byte_t      pre_q, pre_d;
   logic [1:0] phase_q, phase_d;
   logic [1:0] inhibit_q, inhibit_d;
   logic [1:0] pin_sync_q;
   logic       samp_q, samp_d;
   logic       samp_old_q, samp_old_d;
   logic       awh_q, awh_d, wh_q, wh_d, bvalid_q, bvalid_d;
   logic [3:0] awa_q, awa_d;
   byte_t      wd_q, wd_d;
   logic [3:0] ws_q, ws_d;
   logic       rvalid_q, rvalid_d;
   word_t      rdata_q, rdata_d;
   resp_t      bresp_q, bresp_d, rresp_q, rresp_d;
   logic       wdt_out_q, wdt_out_d;

   // prescaler tap: bit n of the count toggles at 1:2^(n+1)
   function automatic logic tap(input byte_t cnt, input logic [2:0] sel);
      tap = cnt[sel];
   endfunction

   ////////////////////////////////////////////////////////////////////
   // derived controls
   logic to_timer, src_ext, edge_fall, cyc, do_write, wr_count;
   logic pin_edge, ext_level, ev_inc, pre_bit_old, pre_tick, ext_evt;
   logic [2:0] ratio;
   assign to_timer  = ~opt_q[`OPT_ASSIGN];
   assign src_ext   = opt_q[`OPT_SRC];
   assign edge_fall = opt_q[`OPT_EDGE];
   assign ratio     = opt_q[`OPT_PS_LSB +: 3];
   // instruction cycle: one enable pulse every four phases
   assign cyc       = (phase_q == `PHASES);
   assign do_write  = awh_q & wh_q & ~bvalid_q;
   assign wr_count  = do_write & (awa_q == `ADDR_COUNT) & ws_q[0];
   // pin edge seen on the second synchroniser stage only; comparing the
   // pin with its own last level avoids a false edge after reset or an
   // edge select change
   assign ext_level = edge_fall ? (samp_old_q & ~pin_sync_q[1])
                                : (~samp_old_q & pin_sync_q[1]);

   ////////////////////////////////////////////////////////////////////
   // two-flop synchroniser on the count pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_sync_q <= 2'h0;
      end else begin
         pin_sync_q <= {pin_sync_q[0], external_count_input};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // timer, prescaler and phase next state
   always_comb begin
      phase_d    = phase_q + 2'h1;
      pre_d      = pre_q;
      count_d    = count_q;
      ctl_d      = ctl_q;
      inhibit_d  = inhibit_q;
      samp_d     = samp_q;
      samp_old_d = pin_sync_q[1];
      wdt_out_d  = 1'b0;
      pin_edge   = 1'b0;
      ev_inc     = 1'b0;
      ext_evt    = 1'b0;
      pre_bit_old = tap(pre_q, ratio);
      pre_tick   = 1'b0;
      // prescaler clock: watchdog tick when assigned to the watchdog, else pin edge in counter mode or cycle in timer mode
      if (to_timer) begin
         if (src_ext) begin
            // divide the raw edge ahead of sampling
            pin_edge = ext_level;
         end else begin
            pin_edge = cyc;
         end
      end else begin
         pin_edge = watchdog_tick; // postscaler after watchdog
      end
      if (!sleep && pin_edge) begin
         pre_d = pre_q + 8'h01;
      end
      pre_tick = pre_bit_old & ~tap(pre_d, ratio);
      if (!to_timer) begin
         wdt_out_d = pre_tick;
      end
      // external events wait for phase two or four; the pending bit keeps
      // a pulse landing between sample points from being lost
      if (src_ext && !sleep) begin
         ext_evt = to_timer ? pre_tick : ext_level;
      end
      if (phase_q[0]) begin
         samp_d = ext_evt;
      end else begin
         samp_d = samp_q | ext_evt;
      end
      if (src_ext) begin
         ev_inc = phase_q[0] & samp_q;
      end else if (to_timer) begin
         ev_inc = pre_tick;
      end else begin
         ev_inc = cyc; // timer mode without prescaler
      end
      if (cyc && inhibit_q != 2'h0) begin
         inhibit_d = inhibit_q - 2'h1;
      end
      // sleep freezes the count
      if (!sleep && ev_inc && (inhibit_q == 2'h0)) begin
         count_d = count_q + 8'h01;
         if (count_q == 8'hFF) begin
            ctl_d[`CTL_FLAG] = 1'b1;
         end
      end
      if (wr_count) begin
         count_d   = wd_q;
         inhibit_d = `WRITE_INHIBIT;
         if (to_timer) begin
            pre_d = 8'h00;
         end
      end
      if (!to_timer && watchdog_clear_instruction) begin
         pre_d = 8'h00;
      end
      if (do_write && awa_q == `ADDR_CONTROL && ws_q[0]) begin
         // a rollover in the same cycle keeps the flag set
         // only a flag newly set this cycle survives the write
         ctl_d = wd_q | (ctl_d & ~ctl_q & (8'h01 << `CTL_FLAG));
      end
   end

   ////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave next state; option written any time
   always_comb begin
      awh_d = awh_q;  awa_d = awa_q;
      wh_d  = wh_q;   wd_d  = wd_q;  ws_d = ws_q;
      bvalid_d = bvalid_q; bresp_d = bresp_q;
      rvalid_d = rvalid_q; rdata_d = rdata_q; rresp_d = rresp_q;
      opt_d = opt_q;
      if (awvalid && awready) begin
         awh_d = 1'b1;
         awa_d = awaddr;
      end
      if (wvalid && wready) begin
         wh_d = 1'b1;
         wd_d = wdata[7:0];
         ws_d = wstrb;
      end
      if (do_write) begin
         awh_d = 1'b0;
         wh_d  = 1'b0;
         bvalid_d = 1'b1;
         bresp_d  = 2'h0;
         if (awa_q == `ADDR_OPTION) begin
            if (ws_q[0]) opt_d = wd_q;
         end else if (awa_q == `ADDR_STATUS) begin
            bresp_d = 2'h2; // read-only
         end else if (awa_q != `ADDR_COUNT && awa_q != `ADDR_CONTROL) begin
            bresp_d = 2'h2;
         end
      end
      if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
      if (arvalid && arready) begin
         rvalid_d = 1'b1;
         rresp_d  = 2'h0;
         rdata_d  = 32'h0000_0000; // prescaler never visible
         if (araddr == `ADDR_COUNT) begin
            rdata_d[7:0] = count_q;
         end else if (araddr == `ADDR_CONTROL) begin
            rdata_d[7:0] = ctl_q;
         end else if (araddr == `ADDR_OPTION) begin
            rdata_d[7:0] = opt_q;
         end else if (araddr == `ADDR_STATUS) begin
            rdata_d[1:0] = inhibit_q;
         end else begin
            rresp_d = 2'h2;
         end
      end else if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= 8'h00;  opt_q <= `OPT_RESET;  ctl_q <= 8'h00;
         pre_q <= 8'h00;    phase_q <= 2'h0;      inhibit_q <= 2'h0;
         samp_q <= 1'b0;    samp_old_q <= 1'b0;   wdt_out_q <= 1'b0;
         awh_q <= 1'b0;     awa_q <= 4'h0;        wh_q <= 1'b0;
         wd_q <= 8'h00;     ws_q <= 4'h0;         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;   rvalid_q <= 1'b0;     rdata_q <= 32'h0000_0000;
         rresp_q <= 2'h0;
      end else begin
         count_q <= count_d;  opt_q <= opt_d;       ctl_q <= ctl_d;
         pre_q <= pre_d;      phase_q <= phase_d;   inhibit_q <= inhibit_d;
         samp_q <= samp_d;    samp_old_q <= samp_old_d;
         wdt_out_q <= wdt_out_d;
         awh_q <= awh_d;      awa_q <= awa_d;       wh_q <= wh_d;
         wd_q <= wd_d;        ws_q <= ws_d;         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;  rvalid_q <= rvalid_d; rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs; request masked by enable bit
   assign awready  = ~awh_q & ~bvalid_q;
   assign wready   = ~wh_q & ~bvalid_q;
   assign bvalid   = bvalid_q;
   assign bresp    = bresp_q;
   assign arready  = ~rvalid_q;
   assign rvalid   = rvalid_q;
   assign rdata    = rdata_q;
   assign rresp    = rresp_q;
   assign timer_irq = ctl_q[`CTL_FLAG] & ctl_q[`CTL_ENABLE];
   assign watchdog_timeout = wdt_out_q;

   ////////////////////////////////////////////////////////////////////
   // checks
   AST_SLEEP_FREEZE: assert property (@(posedge aclk) disable iff (!aresetn)
      sleep && !wr_count |=> count_q == $past(count_q))
      else $error("count moved in sleep");
   AST_INHIBIT: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_count |=> inhibit_q == 2'h2)
      else $error("write did not inhibit");
   AST_NO_INC: assert property (@(posedge aclk) disable iff (!aresetn)
      inhibit_q != 2'h0 && !wr_count |=> count_q == $past(count_q))
      else $error("counted while inhibited");
   AST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
      count_q == 8'hFF ##1 count_q == 8'h00 && !$past(wr_count)
      |-> ctl_q[`CTL_FLAG])
      else $error("rollover lost flag");
   AST_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctl_q[`CTL_ENABLE] |-> !timer_irq)
      else $error("irq not masked");
   AST_PRE_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_count && to_timer |=> pre_q == 8'h00)
      else $error("prescaler not cleared");
   AST_WDT_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
      watchdog_clear_instruction && !to_timer |=> pre_q == 8'h00)
      else $error("watchdog clear missed");
   AST_TIMER_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
      !src_ext && !sleep ##1 1'b1 |-> count_q - $past(count_q) <= 8'h01
      || $past(wr_count))
      else $error("timer stepped by more than one");
   COV_WRAP: cover property (@(posedge aclk) ctl_q[`CTL_FLAG]);
   COV_IRQ: cover property (@(posedge aclk) timer_irq);
   COV_EXT: cover property (@(posedge aclk) src_ext && ev_inc);
endmodule
`default_nettype wire

// [verilog/timer0_params.svh]
// constants for the 8-bit timer/counter with shared prescaler
// assumes a single 25 MHz clock and an AXI4-Lite register slave
`ifndef TIMER0_PARAMS_SVH
`define TIMER0_PARAMS_SVH
`define ADDR_COUNT      4'h0
`define ADDR_CONTROL    4'h4
`define ADDR_OPTION     4'h8
`define ADDR_STATUS     4'hC
`define OPT_RESET       8'hFF
`define OPT_PS_LSB      0
`define OPT_ASSIGN      3
`define OPT_EDGE        4
`define OPT_SRC         5
`define CTL_FLAG        2
`define CTL_ENABLE      5
`define WRITE_INHIBIT   2'h2
`define PHASES          2'h3
`endif

// [verilog/timer0_pkg.sv]
// types for the 8-bit timer/counter
// assumes timer0_params.svh holds the numbers
package timer0_pkg;
   typedef logic [7:0]  byte_t;
   typedef logic [31:0] word_t;
   typedef logic [1:0]  resp_t;
endpackage
